// ===== bench/i2c_host.sv
`timescale 1ns/1ns
module i2c_host (
   input  wire clock,
   input  wire sda_line,
   output reg  scl,
   output reg  sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task q;
      begin
         repeat (10) @(posedge clock);
         #1;
      end
   endtask
   task start_c;
      begin
         sda_low = 1'b0;
         q;
         scl = 1'b1;
         q;
         sda_low = 1'b1;
         q;
         scl = 1'b0;
         q;
      end
   endtask
   task stop_c;
      begin
         sda_low = 1'b1;
         q;
         scl = 1'b1;
         q;
         sda_low = 1'b0;
         q;
      end
   endtask
   task byte_tx(input [7:0] b, output ack);
      integer i;
      begin
         for (i = 7; i >= 0; i = i - 1) begin
            sda_low = ~b[i];
            q;
            scl = 1'b1;
            q;
            q;
            scl = 1'b0;
            q;
         end
         sda_low = 1'b0;
         q;
         scl = 1'b1;
         q;
         ack = !sda_line;
         q;
         scl = 1'b0;
         q;
      end
   endtask
endmodule

// ===== bench/nv_copy_monitor.sv
`timescale 1ns/1ns
module nv_copy_monitor #(
   parameter TO_NV_CYCLES = 50
) (
   input wire        clock,
   input wire        rst_n,
   input wire        power_on_n,
   input wire        scl_in,
   input wire        sda_oe_n,
   input wire [15:0] vol_cfg_reg,
   input wire [15:0] vol_tlow_reg,
   input wire [15:0] nv_cfg_reg,
   input wire [15:0] nv_tlow_reg
);
   reg [20:0] cnt_reg;
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_n || !power_on_n);
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         cnt_reg <= 21'h0;
      else if (vol_cfg_reg[0])
         cnt_reg <= cnt_reg + 21'h1;
      else
         cnt_reg <= 21'h0;
   end
   property p_reload;
      $rose(rst_n) |-> ##[1:2] vol_tlow_reg == nv_tlow_reg;
   endproperty
   a_reload: assert property (p_reload)
      else $error("volatile limit not reloaded after reset");
   property p_ack_edge;
      $changed(sda_oe_n) |-> !scl_in;
   endproperty
   a_ack_edge: assert property (p_ack_edge)
      else $error("data line moved while bus clock high");
   property p_ack_hold;
      $fell(sda_oe_n) |-> !sda_oe_n [*8];
   endproperty
   a_ack_hold: assert property (p_ack_hold)
      else $error("acknowledge too short");
   property p_vol_hold;
      vol_cfg_reg[0] ##1 vol_cfg_reg[0] |-> $stable(vol_tlow_reg);
   endproperty
   a_vol_hold: assert property (p_vol_hold)
      else $error("volatile limit moved during copy");
   property p_nv_when;
      !$stable(nv_tlow_reg) |-> $fell(vol_cfg_reg[0]);
   endproperty
   a_nv_when: assert property (p_nv_when)
      else $error("nonvolatile limit moved outside copy end");
   property p_nv_value;
      $fell(vol_cfg_reg[0]) && !$stable(nv_tlow_reg)
         |-> nv_tlow_reg == $past(vol_tlow_reg);
   endproperty
   a_nv_value: assert property (p_nv_value)
      else $error("programmed limit differs from volatile");
   property p_no_lock;
      $rose(vol_cfg_reg[0]) |-> nv_cfg_reg[2:1] == 2'h0;
   endproperty
   a_no_lock: assert property (p_no_lock)
      else $error("copy started while locked");
   property p_busy_max;
      cnt_reg <= TO_NV_CYCLES + 1;
   endproperty
   a_busy_max: assert property (p_busy_max)
      else $error("busy flag held too long");
endmodule
bind nv_shadow_register_copy nv_copy_monitor #(
   .TO_NV_CYCLES(TO_NV_CYCLES)
) nv_copy_monitor_inst (
   .clock(clock),
   .rst_n(rst_n),
   .power_on_n(power_on_n),
   .scl_in(scl_in),
   .sda_oe_n(sda_oe_n),
   .vol_cfg_reg(vol_cfg_reg),
   .vol_tlow_reg(vol_tlow_reg),
   .nv_cfg_reg(nv_cfg_reg),
   .nv_tlow_reg(nv_tlow_reg)
);

// ===== bench/tb_nv_shadow_register_copy.sv
`timescale 1ns/1ns
`include "nv_copy_defines.vh"
module tb_nv_shadow_register_copy;
   localparam NV_N = 2000;
   localparam [7:0] ADR = {`DEV_TYPE_CODE, 3'h5, 1'b0};
   reg         clock;
   reg         rst_n;
   reg         power_on_n;
   reg         vol_wr_en;
   reg  [1:0]  vol_wr_sel;
   reg  [15:0] vol_wr_data;
   wire        scl;
   wire        sda_low;
   wire        sda_out;
   wire        sda_oe_n;
   wire [15:0] vol_cfg_reg, vol_tlow_reg, vol_thigh_reg;
   wire [15:0] nv_cfg_reg, nv_tlow_reg, nv_thigh_reg;
   wire        nv_busy_flag;
   wire        ptr_wr_reg;
   wire [7:0]  ptr_data_reg;
   integer     failures, checked, cyc, ptr_cnt, n, k;
   reg         busy_seen, ack_a, ack_o;
   reg  [15:0] lk;
   // Pulled-up line, low whenever either party pulls it.
   wire sda_wire = !(sda_low || (!sda_oe_n && !sda_out));
   nv_shadow_register_copy #(
      .TO_VOL_CYCLES(20'h00014),
      .TO_NV_CYCLES(20'h007d0)
   ) nv_shadow_register_copy_inst (
      .clock(clock), .rst_n(rst_n), .power_on_n(power_on_n),
      .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .addr_select_pins(3'h5),
      .vol_wr_en(vol_wr_en), .vol_wr_sel(vol_wr_sel),
      .vol_wr_data(vol_wr_data), .vol_cfg_reg(vol_cfg_reg),
      .vol_tlow_reg(vol_tlow_reg), .vol_thigh_reg(vol_thigh_reg),
      .nv_cfg_reg(nv_cfg_reg), .nv_tlow_reg(nv_tlow_reg),
      .nv_thigh_reg(nv_thigh_reg), .nv_busy_flag(nv_busy_flag),
      .ptr_wr_reg(ptr_wr_reg), .ptr_data_reg(ptr_data_reg)
   );
   i2c_host i2c_host_inst (
      .clock(clock), .sda_line(sda_wire), .scl(scl), .sda_low(sda_low)
   );
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc = cyc + 1;
      if (vol_cfg_reg[0] === 1'b1)
         busy_seen = 1'b1;
      if (ptr_wr_reg === 1'b1)
         ptr_cnt = ptr_cnt + 1;
      if (cyc == 40000) begin
         failures = failures + 1;
         wrap_up;
      end
   end
   task check(input string nm, input [15:0] seen, input [15:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("[FAIL] %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task do_reset(input pwr);
      begin
         rst_n = 1'b0;
         power_on_n = !pwr;
         repeat (10) @(posedge clock);
         #1;
         rst_n = 1'b1;
         power_on_n = 1'b1;
         repeat (5) @(posedge clock);
         #1;
      end
   endtask
   task vwrite(input [1:0] s, input [15:0] d);
      begin
         vol_wr_sel = s;
         vol_wr_data = d;
         vol_wr_en = 1'b1;
         @(posedge clock);
         #1;
         vol_wr_en = 1'b0;
         // Let one edge pass so a following write raises a fresh strobe.
         @(posedge clock);
         #1;
      end
   endtask
   task cmd(input [7:0] adr, input [7:0] op, input rs);
      begin
         busy_seen = 1'b0;
         i2c_host_inst.start_c;
         i2c_host_inst.byte_tx(adr, ack_a);
         i2c_host_inst.byte_tx(op, ack_o);
         if (rs)
            i2c_host_inst.start_c;
         i2c_host_inst.stop_c;
         repeat (40) @(posedge clock);
         #1;
      end
   endtask
   task wait_idle;
      begin
         n = 0;
         while (vol_cfg_reg[0] !== 1'b0 && n < 3000) begin
            @(posedge clock);
            n = n + 1;
         end
         #1;
      end
   endtask
   task t_basic;
      begin
         check("vol_tlow", vol_tlow_reg, `NV_TLOW_DEFAULT);
         check("vol_thigh", vol_thigh_reg, `NV_THIGH_DEFAULT);
         cmd({`DEV_TYPE_CODE, 3'h2, 1'b0}, 8'h01, 1'b0);
         check("bad_addr_ack", ack_a, 1'b0);
         cmd(ADR, 8'h03, 1'b0);
         check("addr_ack", ack_a, 1'b1);
         check("ptr_data", ptr_data_reg, 8'h03);
         $display("t_basic done");
      end
   endtask
   task t_to_nv;
      begin
         vwrite(2'h1, 16'h1234);
         vwrite(2'h2, 16'h2345);
         cmd(ADR, `OP_COPY_TO_NV, 1'b0);
         check("ack_48", ack_o, 1'b1);
         check("busy", nv_busy_flag, 1'b1);
         cmd(ADR, `OP_COPY_TO_VOL, 1'b0);
         check("ack_busy", ack_o, 1'b1);
         wait_idle;
         check("nv_time", n <= NV_N, 1'b1);
         check("nv_tlow", nv_tlow_reg, 16'h1234);
         check("nv_thigh", nv_thigh_reg, 16'h2345);
         busy_seen = 1'b0;
         repeat (60) @(posedge clock);
         #1;
         check("no_relaunch", busy_seen, 1'b0);
         check("ptr_cnt", ptr_cnt[15:0], 16'h0001);
         // A plain reset must reload the newly programmed defaults.
         do_reset(1'b0);
         check("rst_tlow", vol_tlow_reg, 16'h1234);
         check("rst_thigh", vol_thigh_reg, 16'h2345);
         check("rst_nv", nv_tlow_reg, 16'h1234);
         $display("t_to_nv done");
      end
   endtask
   task t_to_vol;
      begin
         vwrite(2'h1, 16'h0abc);
         cmd(ADR, `OP_COPY_TO_VOL, 1'b1);
         check("abort_busy", busy_seen, 1'b0);
         check("abort_vol", vol_tlow_reg, 16'h0abc);
         cmd(ADR, `OP_COPY_TO_NV, 1'b1);
         check("abort_nv", nv_tlow_reg, 16'h1234);
         cmd(ADR, `OP_COPY_TO_VOL, 1'b0);
         check("ack_b8", ack_o, 1'b1);
         check("copy_busy", busy_seen, 1'b1);
         check("vol_cfg", vol_cfg_reg, `NV_CFG_DEFAULT);
         check("vol_tlow", vol_tlow_reg, 16'h1234);
         $display("t_to_vol done");
      end
   endtask
   task t_lock;
      begin
         for (k = 0; k < 2; k = k + 1) begin
            do_reset(1'b1);
            lk = k ? 16'h0002 : 16'h0004;
            vwrite(2'h0, lk);
            cmd(ADR, `OP_COPY_TO_NV, 1'b0);
            wait_idle;
            check("nv_cfg", nv_cfg_reg, lk);
            cmd(ADR, `OP_COPY_TO_VOL, 1'b0);
            check("lock_ack", ack_o, 1'b1);
            check("lock_vol", busy_seen, 1'b0);
            cmd(ADR, `OP_COPY_TO_NV, 1'b0);
            check("lock_nv", busy_seen, 1'b0);
         end
         $display("t_lock done");
      end
   endtask
   task wrap_up;
      begin
         $display("checks %0d failures %0d", checked, failures);
         if (failures == 0 && checked > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   initial begin
      failures = 0;
      checked = 0;
      cyc = 0;
      ptr_cnt = 0;
      busy_seen = 1'b0;
      vol_wr_en = 1'b0;
      vol_wr_sel = 2'h0;
      vol_wr_data = 16'h0000;
      do_reset(1'b1);
      t_basic;
      t_to_nv;
      t_to_vol;
      t_lock;
      wrap_up;
   end
endmodule

// ===== rtl/copy_timer.v
`timescale 1ns/1ns
module copy_timer #(
   parameter CNT_W = 20
) (
   input  wire             clock,
   input  wire             rst_n,
   input  wire             start,
   input  wire [CNT_W-1:0] load_value,
   output reg              running,
   output reg              done
);
   reg [CNT_W-1:0] count_reg;

   // A load value of zero is treated as one cycle.
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= {CNT_W{1'b0}};
         running   <= 1'b0;
         done      <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start && !running) begin
            count_reg <= load_value;
            running   <= 1'b1;
         end else if (running) begin
            if (count_reg <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
               running <= 1'b0;
               done    <= 1'b1;
            end else begin
               count_reg <= count_reg - {{(CNT_W-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule

// ===== rtl/i2c_pin_sync.v
`timescale 1ns/1ns
module i2c_pin_sync (
   input  wire clock,
   input  wire rst_n,
   input  wire scl_pin,
   input  wire sda_pin,
   output wire sda_level,
   output wire scl_rise,
   output wire scl_fall,
   output wire start_seen,
   output wire stop_seen
);
   reg scl_meta_reg;
   reg scl_sync_reg;
   reg scl_prev_reg;
   reg sda_meta_reg;
   reg sda_sync_reg;
   reg sda_prev_reg;

   // An idle bus floats high, so every stage resets to one.
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         scl_meta_reg <= 1'b1;
         scl_sync_reg <= 1'b1;
         scl_prev_reg <= 1'b1;
         sda_meta_reg <= 1'b1;
         sda_sync_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         scl_meta_reg <= scl_pin;
         scl_sync_reg <= scl_meta_reg;
         scl_prev_reg <= scl_sync_reg;
         sda_meta_reg <= sda_pin;
         sda_sync_reg <= sda_meta_reg;
         sda_prev_reg <= sda_sync_reg;
      end
   end

   assign sda_level  = sda_sync_reg;
   assign scl_rise   = scl_sync_reg & ~scl_prev_reg;
   assign scl_fall   = ~scl_sync_reg & scl_prev_reg;
   assign start_seen = scl_sync_reg & scl_prev_reg &
                       sda_prev_reg & ~sda_sync_reg;
   assign stop_seen  = scl_sync_reg & scl_prev_reg &
                       ~sda_prev_reg & sda_sync_reg;
endmodule

// ===== rtl/nv_copy_defines.vh
`ifndef NV_COPY_DEFINES_VH
`define NV_COPY_DEFINES_VH
// Behaviour
// - Reset reloads volatile registers from nonvolatile copies.
// - Matching write address byte is acknowledged.
// - Opcode b8h requests copy to volatile, acknowledged.
// - Opcode 48h requests copy to nonvolatile, acknowledged.
// - Copy starts on Stop, repeated Start aborts.
// - Busy flag held high for whole copy.
// - Aborted copy leaves volatile registers unchanged.
// - Aborted copy leaves nonvolatile registers unchanged.
// - No copy to volatile when busy or locked.
// - No copy to nonvolatile when busy or locked.
// - Suppressed opcode is still acknowledged.
// - Copy to nonvolatile sets new reset defaults.
// - Opcode replaces pointer byte, pointer unchanged.

`define CLOCK_PERIOD_NS      10
`define DEV_TYPE_CODE        4'h9
`define OP_COPY_TO_VOL       8'hb8
`define OP_COPY_TO_NV        8'h48

`define CFG_BUSY_BIT         0
`define CFG_LOCKDOWN_BIT     1
`define CFG_REVERSIBLE_LOCK_BIT_BIT         2

`define NV_CFG_DEFAULT       16'h0000
`define NV_TLOW_DEFAULT      16'h4b00
`define NV_THIGH_DEFAULT     16'h5000
`define VOL_RESET_VALUE      16'h0000

`define SEL_CFG              2'h0
`define SEL_TLOW             2'h1
`define SEL_THIGH            2'h2

`define COPY_TO_VOL_TIME_NS  200000
`define COPY_TO_NV_TIME_NS   10000000
// Cycle counts are the times above at the clock period, sized for the
// copy counter.
`define COPY_TO_VOL_CYCLES   20'h04e20
`define COPY_TO_NV_CYCLES    20'hf4240
`define COPY_CNT_W           20
`endif

// ===== rtl/nv_shadow_register_copy.v
`timescale 1ns/1ns
`include "nv_copy_defines.vh"
module nv_shadow_register_copy #(
   parameter [`COPY_CNT_W-1:0] TO_VOL_CYCLES = `COPY_TO_VOL_CYCLES,
   parameter [`COPY_CNT_W-1:0] TO_NV_CYCLES  = `COPY_TO_NV_CYCLES
) (
   input  wire        clock,
   input  wire        rst_n,
   input  wire        power_on_n,
   input  wire        scl_in,
   input  wire        sda_in,
   output reg         sda_out,
   output reg         sda_oe_n,
   input  wire [2:0]  addr_select_pins,
   input  wire        vol_wr_en,
   input  wire [1:0]  vol_wr_sel,
   input  wire [15:0] vol_wr_data,
   output reg  [15:0] vol_cfg_reg,
   output reg  [15:0] vol_tlow_reg,
   output reg  [15:0] vol_thigh_reg,
   output reg  [15:0] nv_cfg_reg,
   output reg  [15:0] nv_tlow_reg,
   output reg  [15:0] nv_thigh_reg,
   output reg         nv_busy_flag,
   output reg         ptr_wr_reg,
   output reg  [7:0]  ptr_data_reg
);
   // The bus side only listens and acknowledges: it never sends data, so
   // the data pin is either released or pulled low for an acknowledge.
   // ST_RX gathers eight bits, ST_ACK holds the acknowledge for the ninth
   // clock and ST_IGNORE waits for the next Start or Stop after a byte that
   // was not meant for this device.
   localparam [1:0] ST_IDLE   = 2'h0;
   localparam [1:0] ST_RX     = 2'h1;
   localparam [1:0] ST_ACK    = 2'h2;
   localparam [1:0] ST_IGNORE = 2'h3;

   // The phase tracks which byte of the transfer is being received. A copy
   // opcode moves straight to PH_DONE, so later bytes are not acknowledged.
   localparam [1:0] PH_ADDR = 2'h0;
   localparam [1:0] PH_CMD  = 2'h1;
   localparam [1:0] PH_DATA = 2'h2;
   localparam [1:0] PH_DONE = 2'h3;

   wire       sda_level;
   wire       scl_rise;
   wire       scl_fall;
   wire       start_seen;
   wire       stop_seen;
   wire       timer_running;
   wire       timer_done;

   reg  [1:0] state_reg;
   reg  [1:0] phase_reg;
   reg  [3:0] bit_cnt_reg;
   reg  [7:0] shift_reg;
   reg  [2:0] sel_meta_reg;
   reg  [2:0] sel_sync_reg;
   reg        pend_valid_reg;
   reg        pend_to_nv_reg;
   reg        copy_to_nv_reg;
   reg        launch_reg;
   reg        reload_reg;

   wire       busy_now;
   wire       locked;
   wire       copy_allowed;
   wire       addr_match;
   wire       is_op_vol;
   wire       is_op_nv;

   // Both bus pins come from another clock domain and are resynchronised
   // before any edge or condition is decoded from them.
   i2c_pin_sync u_pin_sync (
      .clock      (clock),
      .rst_n      (rst_n),
      .scl_pin    (scl_in),
      .sda_pin    (sda_in),
      .sda_level  (sda_level),
      .scl_rise   (scl_rise),
      .scl_fall   (scl_fall),
      .start_seen (start_seen),
      .stop_seen  (stop_seen)
   );

   // One timer serves both directions; the load value is chosen by the
   // direction latched at the Stop, which stays fixed for the whole copy.
   copy_timer #(
      .CNT_W (`COPY_CNT_W)
   ) u_copy_timer (
      .clock      (clock),
      .rst_n      (rst_n),
      .start      (launch_reg),
      .load_value (copy_to_nv_reg ? TO_NV_CYCLES : TO_VOL_CYCLES),
      .running    (timer_running),
      .done       (timer_done)
   );

   // The select pins are straps but still pass two stages before use.
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sel_meta_reg <= 3'h0;
         sel_sync_reg <= 3'h0;
      end else begin
         sel_meta_reg <= addr_select_pins;
         sel_sync_reg <= sel_meta_reg;
      end
   end

   // Busy covers the whole window from Stop to the end of the copy: the
   // launch cycle and the reset reload are included so that a command or a
   // local write arriving in those cycles cannot slip in before the flag.
   assign busy_now = vol_cfg_reg[`CFG_BUSY_BIT] | launch_reg |
                     timer_running | reload_reg;
   // Either lock bit blocks both copy directions and the local write port.
   // Since nothing else writes the nonvolatile set, a lock stays in force
   // until power_on_n restores the factory defaults.
   assign locked   = nv_cfg_reg[`CFG_REVERSIBLE_LOCK_BIT_BIT] |
                     nv_cfg_reg[`CFG_LOCKDOWN_BIT];
   assign copy_allowed = ~busy_now & ~locked;
   // The read bit must be zero: read transfers are not served by this
   // block and are left unacknowledged.
   // address and select match
   assign addr_match = (shift_reg[7:4] == `DEV_TYPE_CODE) &&
                       (shift_reg[3:1] == sel_sync_reg) &&
                       !shift_reg[0];
   assign is_op_vol  = (shift_reg == `OP_COPY_TO_VOL);
   assign is_op_nv   = (shift_reg == `OP_COPY_TO_NV);

   // Bus side: byte reception, acknowledge and command capture.
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_reg      <= ST_IDLE;
         phase_reg      <= PH_ADDR;
         bit_cnt_reg    <= 4'h0;
         shift_reg      <= 8'h00;
         sda_out        <= 1'b0;
         sda_oe_n       <= 1'b1;
         pend_valid_reg <= 1'b0;
         pend_to_nv_reg <= 1'b0;
         copy_to_nv_reg <= 1'b0;
         launch_reg     <= 1'b0;
         ptr_wr_reg     <= 1'b0;
         ptr_data_reg   <= 8'h00;
      end else begin
         sda_out    <= 1'b0;
         launch_reg <= 1'b0;
         ptr_wr_reg <= 1'b0;
         // A Start or Stop wins over any bit activity in the same cycle,
         // since both are only seen while the bus clock is high.
         if (start_seen) begin
            pend_valid_reg <= 1'b0;
            sda_oe_n       <= 1'b1;
            state_reg      <= ST_RX;
            phase_reg      <= PH_ADDR;
            bit_cnt_reg    <= 4'h0;
         end else if (stop_seen) begin
            sda_oe_n       <= 1'b1;
            state_reg      <= ST_IDLE;
            pend_valid_reg <= 1'b0;
            // Busy and lock are judged at the Stop, not at the opcode, so
            // a copy that ends between the two still lets the command run.
            // Stop launches copy
            if (pend_valid_reg && copy_allowed) begin
               launch_reg     <= 1'b1;
               copy_to_nv_reg <= pend_to_nv_reg;
            end
         end else begin
            case (state_reg)
               ST_RX: begin
                  // Bits are taken on the rising bus clock; the acknowledge
                  // decision waits for the falling edge after the eighth bit
                  // so that the pin only changes while the clock is low.
                  if (scl_rise && bit_cnt_reg != 4'h8) begin
                     shift_reg   <= {shift_reg[6:0], sda_level};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                     case (phase_reg)
                        PH_ADDR: begin
                           if (addr_match) begin
                              sda_oe_n  <= 1'b0;
                              state_reg <= ST_ACK;
                           end else begin
                              state_reg <= ST_IGNORE;
                           end
                        end
                        PH_CMD: begin
                           sda_oe_n  <= 1'b0;
                           state_reg <= ST_ACK;
                           if (is_op_vol || is_op_nv) begin
                              pend_valid_reg <= 1'b1;
                              pend_to_nv_reg <= is_op_nv;
                           end else begin
                              ptr_wr_reg   <= 1'b1;
                              ptr_data_reg <= shift_reg;
                           end
                        end
                        PH_DATA: begin
                           sda_oe_n  <= 1'b0;
                           state_reg <= ST_ACK;
                        end
                        default: begin
                           state_reg <= ST_IGNORE;
                        end
                     endcase
                  end
               end
               ST_ACK: begin
                  // The acknowledge is dropped on the falling edge that ends
                  // the ninth clock, which keeps the data pin steady while
                  // the master samples it.
                  if (scl_fall) begin
                     sda_oe_n    <= 1'b1;
                     bit_cnt_reg <= 4'h0;
                     state_reg   <= ST_RX;
                     case (phase_reg)
                        PH_ADDR: phase_reg <= PH_CMD;
                        PH_CMD:  phase_reg <= pend_valid_reg ?
                                              PH_DONE : PH_DATA;
                        default: phase_reg <= phase_reg;
                     endcase
                  end
               end
               ST_IGNORE: begin
                  // Nothing is driven until a Start or Stop restarts the bus.
                  sda_oe_n <= 1'b1;
               end
               default: begin
                  state_reg <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // Volatile set: reset reload, copies from nonvolatile and local writes.
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         vol_cfg_reg   <= `VOL_RESET_VALUE;
         vol_tlow_reg  <= `VOL_RESET_VALUE;
         vol_thigh_reg <= `VOL_RESET_VALUE;
         reload_reg    <= 1'b1;
         nv_busy_flag  <= 1'b0;
      end else begin
         reload_reg   <= 1'b0;
         // The output flag trails the internal bit by one cycle so that it
         // comes straight from a flip-flop.
         nv_busy_flag <= vol_cfg_reg[`CFG_BUSY_BIT];
         // Priority: reload, then copy start, then copy end, then the local
         // port. The local port is refused whenever busy, so it can never
         // overwrite a value that a copy is about to deliver.
         if (reload_reg) begin
            vol_cfg_reg   <= nv_cfg_reg & ~(16'h0001 << `CFG_BUSY_BIT);
            vol_tlow_reg  <= nv_tlow_reg;
            vol_thigh_reg <= nv_thigh_reg;
         end else if (launch_reg) begin
            vol_cfg_reg[`CFG_BUSY_BIT] <= 1'b1;
         end else if (timer_done) begin
            vol_cfg_reg[`CFG_BUSY_BIT] <= 1'b0;
            if (!copy_to_nv_reg) begin
               vol_cfg_reg   <= nv_cfg_reg &
                                ~(16'h0001 << `CFG_BUSY_BIT);
               vol_tlow_reg  <= nv_tlow_reg;
               vol_thigh_reg <= nv_thigh_reg;
            end
         end else if (vol_wr_en && !busy_now && !locked) begin
            // The busy bit stays under hardware control.
            case (vol_wr_sel)
               `SEL_CFG: vol_cfg_reg <= (vol_wr_data &
                          ~(16'h0001 << `CFG_BUSY_BIT));
               `SEL_TLOW:  vol_tlow_reg  <= vol_wr_data;
               `SEL_THIGH: vol_thigh_reg <= vol_wr_data;
               default:    vol_tlow_reg  <= vol_tlow_reg;
            endcase
         end
      end
   end

   // Nonvolatile set survives rst_n; only a true power-on reloads its factory defaults.
   // The copy programs the whole set in a single edge at the end of the
   // timed interval; an aborted or refused copy never reaches this point,
   // so the set stays untouched.
   always @(posedge clock or negedge power_on_n) begin
      if (!power_on_n) begin
         nv_cfg_reg   <= `NV_CFG_DEFAULT;
         nv_tlow_reg  <= `NV_TLOW_DEFAULT;
         nv_thigh_reg <= `NV_THIGH_DEFAULT;
      end else if (timer_done && copy_to_nv_reg) begin
         nv_cfg_reg   <= vol_cfg_reg & ~(16'h0001 << `CFG_BUSY_BIT);
         nv_tlow_reg  <= vol_tlow_reg;
         nv_thigh_reg <= vol_thigh_reg;
      end
   end
endmodule
